// ### hw/mppio_sync.sv
// Three-stage pin synchroniser with change agreement and edge pulses.
`timescale 1ns/1ns
module mppio_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pins and results
  mppio_sync_if.snk sp
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, lvl_ff;
  logic [W-1:0] nxt_lvl;
  logic [2:0]   fill_ff, nxt_fill;
  logic         primed;

  // Edges wait until the stages hold real pin samples, so a pin that is
  // high at reset cannot fake a rising edge against the cleared level.
  assign primed = (fill_ff == 3'(mppio_pkg::SYNC_LEN + 1));

  // A change is taken only once stages two and three agree.
  always_comb begin
    nxt_lvl  = lvl_ff;
    nxt_fill = primed ? fill_ff : fill_ff + 3'h1;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_lvl[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      lvl_ff  <= '0;
      fill_ff <= 3'h0;
    end else begin
      s1_ff   <= sp.raw;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      lvl_ff  <= nxt_lvl;
      fill_ff <= nxt_fill;
    end
  end

  assign sp.clean = lvl_ff;
  assign sp.rise  = nxt_lvl & ~lvl_ff & {W{primed}};
  assign sp.fall  = ~nxt_lvl & lvl_ff & {W{primed}};
endmodule

// ### hw/multiport_parallel_io.sv
// Twelve 4-bit parallel ports with pull-up groups, direction and edge flags.
`timescale 1ns/1ns
module multiport_parallel_io #(
  parameter int FILT_CYC = mppio_pkg::FILT_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // CPU writes: output latches, directions per port
  input  wire logic [3:0] latchWrData,
  input  wire logic [11:0] latchWrEn,
  input  wire logic [3:0] dirBitsP3,
  input  wire logic [3:0] dirBitsP6,
  input  wire logic       dirNibP2,
  input  wire logic       dirNibP7,
  input  wire logic       dirNibP8,
  input  wire logic       dirNibP9,
  // Pull-up group enables
  input  wire logic       pullupSerialGrp,
  input  wire logic [11:0] pullupNibbleEn,
  // Flag clears
  input  wire logic       risingTestClr,
  input  wire logic       keyReturnClr,
  // Pin inputs
  input  wire logic [3:0] p0In,
  input  wire logic [3:0] p1In,
  input  wire logic [3:0] p11In,
  input  wire logic [47:0] ioPinIn,
  // Pin outputs, output enables are active low, pull-up enables active high
  output logic [47:0] ioPinOut,
  output logic [47:0] ioPinOeN,
  output logic [2:0]  p0PullupEn,
  output logic [11:0] pullupEn,
  // CPU reads
  output logic [47:0] portRdData,
  output logic        risingTestFlag,
  output logic        keyReturnFlag,
  output logic [3:0]  p1Filtered
);
  // ---------------------------------------------------------------------
  // Synchronisers for all pins
  // ---------------------------------------------------------------------
  mppio_sync_if #(.W(60)) syn ();
  assign syn.raw = {p11In, p1In, p0In, ioPinIn};
  mppio_sync #(.W(60)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .sp   (syn.snk)
  );
  logic [47:0] ioSync;
  logic [3:0]  p0Sync, p1Sync, p11Sync;
  assign ioSync  = syn.clean[47:0];
  assign p0Sync  = syn.clean[51:48];
  assign p1Sync  = syn.clean[55:52];
  assign p11Sync = syn.clean[59:56];

  // ---------------------------------------------------------------------
  // Output latches and directions
  // ---------------------------------------------------------------------
  logic [47:0] latch_ff, nxt_latch;
  logic [47:0] dirOut;
  always_comb begin
    nxt_latch = latch_ff;
    for (int p = 0; p < 12; p++) begin
      if (latchWrEn[p]) begin
        nxt_latch[p*4 +: 4] = latchWrData;
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latch_ff <= {12{mppio_pkg::OD_RST}};
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  // Index 0,1,11 are input ports; 4,5,10 are open drain.
  always_comb begin
    dirOut = '0;
    dirOut[2*4 +: 4] = {4{dirNibP2}};
    dirOut[3*4 +: 4] = dirBitsP3;
    dirOut[6*4 +: 4] = dirBitsP6;
    dirOut[7*4 +: 4] = {4{dirNibP7}};
    dirOut[8*4 +: 4] = {4{dirNibP8}};
    dirOut[9*4 +: 4] = {4{dirNibP9}};
  end

  genvar g;
  generate
    for (g = 0; g < 12; g++) begin : g_port
      if (g == 4 || g == 5 || g == 10) begin : g_od
        // Open drain: only a zero latch pulls the pin low.
        assign ioPinOut[g*4 +: 4] = 4'h0;
        assign ioPinOeN[g*4 +: 4] = latch_ff[g*4 +: 4];
      end else begin : g_cmos
        assign ioPinOut[g*4 +: 4] = latch_ff[g*4 +: 4];
        assign ioPinOeN[g*4 +: 4] = ~dirOut[g*4 +: 4];
      end
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Pull-up groups
  // ---------------------------------------------------------------------
  logic [2:0]  pu0_ff, nxt_pu0;
  logic [11:0] pu_ff, nxt_pu;
  always_comb begin
    nxt_pu0 = pullupSerialGrp ? mppio_pkg::SER_MASK : 3'h0;
    nxt_pu  = '0;
    for (int p = 0; p < 12; p++) begin
      if (p == 1 || p == 2 || p == 3 || p == 6 || p == 7 || p == 8 || p == 9) begin
        nxt_pu[p] = pullupNibbleEn[p];
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pu0_ff <= 3'h0;
      pu_ff  <= 12'h000;
    end else begin
      pu0_ff <= nxt_pu0;
      pu_ff  <= nxt_pu;
    end
  end
  assign p0PullupEn = pu0_ff;
  assign pullupEn   = pu_ff;

  // ---------------------------------------------------------------------
  // Port one noise filter: a level must hold FILT_CYC + 1 cycles
  // ---------------------------------------------------------------------
  mppio_pkg::mppio_flt_type fst_ff, nxt_fst;
  logic [7:0] fcnt_ff, nxt_fcnt;
  logic [3:0] p1f_ff, nxt_p1f;
  always_comb begin
    nxt_fst  = fst_ff;
    nxt_fcnt = fcnt_ff;
    nxt_p1f  = p1f_ff;
    case (fst_ff)
      mppio_pkg::MPPIO_FLT_IDLE: begin
        nxt_fcnt = 8'h00;
        if (p1Sync != p1f_ff) begin
          nxt_fst = mppio_pkg::MPPIO_FLT_WAIT;
        end
      end
      mppio_pkg::MPPIO_FLT_WAIT: begin
        if (p1Sync == p1f_ff) begin
          nxt_fst = mppio_pkg::MPPIO_FLT_IDLE; // Glitch rejected.
        end else if (nxt_fcnt >= 8'(FILT_CYC - 1)) begin
          nxt_p1f = p1Sync;
          nxt_fst = mppio_pkg::MPPIO_FLT_IDLE;
        end else begin
          nxt_fcnt = fcnt_ff + 8'h01;
        end
      end
      default: nxt_fst = mppio_pkg::MPPIO_FLT_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fst_ff  <= mppio_pkg::MPPIO_FLT_IDLE;
      fcnt_ff <= 8'h00;
      p1f_ff  <= 4'h0;
    end else begin
      fst_ff  <= nxt_fst;
      fcnt_ff <= nxt_fcnt;
      p1f_ff  <= nxt_p1f;
    end
  end
  assign p1Filtered = p1f_ff;

  // ---------------------------------------------------------------------
  // Testable edge flags; a new edge wins over a clear
  // ---------------------------------------------------------------------
  logic rtf_ff, nxt_rtf, krf_ff, nxt_krf;
  logic [7:0] keyFall;
  assign keyFall = {syn.fall[7*4 +: 4], syn.fall[6*4 +: 4]};
  always_comb begin
    nxt_rtf = syn.rise[54] | (rtf_ff & ~risingTestClr);
    nxt_krf = (|keyFall) | (krf_ff & ~keyReturnClr);
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rtf_ff <= 1'b0;
      krf_ff <= 1'b0;
    end else begin
      rtf_ff <= nxt_rtf;
      krf_ff <= nxt_krf;
    end
  end
  assign risingTestFlag = rtf_ff;
  assign keyReturnFlag  = krf_ff;

  // ---------------------------------------------------------------------
  // Read data: synchronised pin levels for every port
  // ---------------------------------------------------------------------
  always_comb begin
    portRdData = ioSync;
    portRdData[0*4 +: 4]  = p0Sync;
    portRdData[1*4 +: 4]  = p1Sync;
    portRdData[11*4 +: 4] = p11Sync;
  end
endmodule

// ### include/mppio_pkg.sv
// Package with constants shared by the multiport parallel I/O block.
package mppio_pkg;
  localparam int NIB       = 4;
  localparam int KEYS      = 8;
  localparam int SYNC_LEN  = 3;
  localparam int FILT_NS   = 64;
  localparam int CLK_NS    = 8;
  localparam int FILT_CYC  = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] DIR_RST   = 4'h0;
  localparam logic [3:0] LATCH_RST = 4'h0;
  localparam logic [3:0] OD_RST    = 4'hF;
  localparam logic [2:0] SER_MASK  = 3'h7;
  typedef enum logic [1:0] {
    MPPIO_FLT_IDLE = 2'h1,
    MPPIO_FLT_WAIT = 2'h2
  } mppio_flt_type;
endpackage

// ### include/mppio_sync_if.sv
// Interface carrying raw pins into the synchroniser and clean levels back.
`timescale 1ns/1ns
interface mppio_sync_if #(parameter int W = 4);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output raw, input clean, rise, fall);
  modport snk (input raw, output clean, rise, fall);
endinterface

// ### tb/mppio_asserts.sv
// Checker on the port block pins and flags.
`timescale 1ns/1ns
module mppio_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Watched ports
  input wire logic [3:0]  latchWrData,
  input wire logic [11:0] latchWrEn,
  input wire logic [3:0]  dirBitsP3,
  input wire logic        pullupSerialGrp,
  input wire logic [11:0] pullupNibbleEn,
  input wire logic        risingTestClr,
  input wire logic        keyReturnClr,
  input wire logic [3:0]  p1In,
  input wire logic [3:0]  p11In,
  input wire logic [47:0] ioPinIn,
  input wire logic [47:0] ioPinOeN,
  input wire logic [2:0]  p0PullupEn,
  input wire logic [11:0] pullupEn,
  input wire logic [47:0] portRdData,
  input wire logic        risingTestFlag,
  input wire logic        keyReturnFlag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Windows allow one edge of slack on the four-edge synchroniser path.
  sequence p1Rise;
    !p1In[2] [*3] ##1 (p1In[2] && !risingTestClr) [*6];
  endsequence
  sequence keyFall;
    $stable(ioPinIn[31:24]) [*3] ##1 (|($past(ioPinIn[31:24]) & ~ioPinIn[31:24])) ##1
      (!keyReturnClr && $stable(ioPinIn[31:24])) [*5];
  endsequence
  p3_dir_a: assert property (ioPinOeN[15:12] == ~dirBitsP3) else $error("p3 dir");
  in_only_a: assert property (&{ioPinOeN[7:0], ioPinOeN[47:44]}) else $error("in drv");
  od_latch_a: assert property ($past(latchWrEn[4]) |->
    ioPinOeN[19:16] == $past(latchWrData)) else $error("od latch");
  grp_pull_a: assert property (p0PullupEn == {3{$past(pullupSerialGrp)}}) else $error("grp");
  nib_pull_a: assert property ((pullupEn & 12'h3CE) ==
    ($past(pullupNibbleEn) & 12'h3CE)) else $error("nib");
  rise_flag_a: assert property (p1Rise |-> risingTestFlag) else $error("rise");
  key_flag_a: assert property (keyFall |-> keyReturnFlag) else $error("key");
  rd_sync_a: assert property ($changed(p11In) ##1 $stable(p11In)[*5] |->
    portRdData[47:44] == p11In) else $error("read");
endmodule
bind multiport_parallel_io mppio_asserts mppio_asserts_inst (.clk, .rstn, .latchWrData,
  .latchWrEn, .dirBitsP3, .pullupSerialGrp, .pullupNibbleEn, .risingTestClr,
  .keyReturnClr, .p1In, .p11In, .ioPinIn, .ioPinOeN, .p0PullupEn, .pullupEn,
  .portRdData, .risingTestFlag, .keyReturnFlag);

// ### tb/mppio_pins.sv
// Model of the pins and parts hung on the ports.
`timescale 1ns/1ns
module mppio_pins (
  // Device side
  input wire logic [47:0] ioPinOut,
  input wire logic [47:0] ioPinOeN,
  // Outside drivers
  input wire logic [47:0] extVal,
  input wire logic [47:0] extEn,
  // Pin levels
  output logic [47:0]     ioPinIn
);
  // Wired-AND; an undriven pin rests high as if pulled up.
  assign ioPinIn = (ioPinOut | ioPinOeN) & (extVal | ~extEn);
endmodule

// ### tb/testbench.sv
// Self-checking bench for the port block.
`timescale 1ns/1ns
module testbench;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  latchWrData = 4'h0, dirBitsP3 = 4'h0, dirBitsP6 = 4'h0;
  logic [3:0]  p0In = 4'h0, p1In = 4'h0, p11In = 4'h0, p1Filtered;
  logic [11:0] latchWrEn = 12'h000, pullupNibbleEn = 12'h000, pullupEn;
  logic        dirNibP2 = 1'b0, dirNibP7 = 1'b0, dirNibP8 = 1'b0, dirNibP9 = 1'b0;
  logic        pullupSerialGrp = 1'b0, risingTestClr = 1'b0, keyReturnClr = 1'b0;
  logic [47:0] extVal = 48'h0, extEn = 48'h0, ioPinIn, ioPinOut, ioPinOeN, portRdData;
  logic [2:0]  p0PullupEn;
  logic        risingTestFlag, keyReturnFlag;
  int          errCount = 0;
  int          checkCount = 0;
  always #4 clk = ~clk;
  multiport_parallel_io #(.FILT_CYC(2)) multiport_parallel_io_inst (.clk, .rstn,
    .latchWrData, .latchWrEn, .dirBitsP3, .dirBitsP6, .dirNibP2, .dirNibP7, .dirNibP8,
    .dirNibP9, .pullupSerialGrp, .pullupNibbleEn, .risingTestClr, .keyReturnClr, .p0In,
    .p1In, .p11In, .ioPinIn, .ioPinOut, .ioPinOeN, .p0PullupEn, .pullupEn, .portRdData,
    .risingTestFlag, .keyReturnFlag, .p1Filtered);
  mppio_pins mppio_pins_inst (.ioPinOut, .ioPinOeN, .extVal, .extEn, .ioPinIn);
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [47:0] e, input logic [47:0] g);
    checkCount++;
    if (e !== g) begin
      errCount++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] d, input logic [11:0] m);
    @(posedge clk);
    latchWrData <= d;
    latchWrEn <= m;
    @(posedge clk);
    latchWrEn <= 12'h000;
    wt(1);
  endtask
  task automatic clr();
    @(posedge clk);
    {risingTestClr, keyReturnClr} <= 2'h3;
    @(posedge clk);
    {risingTestClr, keyReturnClr} <= 2'h0;
    wt(1);
    chk(2'h0, {risingTestFlag, keyReturnFlag});
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_reset();
    chk(48'hFFFF_FFFF_FFFF, ioPinOeN);
    chk(17'h0, {pullupEn, p0PullupEn, risingTestFlag, keyReturnFlag});
    $display("reset test done");
  endtask
  task automatic t_dir();
    @(posedge clk);
    dirBitsP3 <= 4'hF;
    dirBitsP6 <= 4'h6;
    wr(4'hA, 12'h048);
    chk(8'hA0, {ioPinOut[15:12], ioPinOeN[15:12]});
    chk(8'h9B, {ioPinOeN[27:24], ioPinIn[27:24]});
    @(posedge clk);
    {dirBitsP3, dirBitsP6} <= 8'h00;
    wt(2);
    chk(8'hFF, {ioPinOeN[27:24], ioPinOeN[15:12]});
    $display("direction test done");
  endtask
  task automatic t_nib();
    @(posedge clk);
    {dirNibP2, dirNibP7, dirNibP8, dirNibP9} <= 4'hF;
    wr(4'h5, 12'hFFF);
    chk(48'hF500_0F55_F0FF, ioPinOeN);
    @(posedge clk);
    {dirNibP2, dirNibP7, dirNibP8, dirNibP9} <= 4'h0;
    wr(4'h0, 12'h410);
    wt(5);
    chk(8'h00, {portRdData[43:40], portRdData[19:16]});
    wr(4'hF, 12'hFFF);
    @(posedge clk);
    extEn[43:40] <= 4'hF;
    extVal[43:40] <= 4'h6;
    wt(6);
    chk(8'hF6, {ioPinOeN[43:40], portRdData[43:40]});
    @(posedge clk);
    extEn <= 48'h0;
    $display("nibble test done");
  endtask
  task automatic t_pull();
    @(posedge clk);
    pullupSerialGrp <= 1'b1;
    pullupNibbleEn <= 12'hFFF;
    wt(2);
    chk(15'h73CE, {p0PullupEn, pullupEn});
    @(posedge clk);
    pullupSerialGrp <= 1'b0;
    pullupNibbleEn <= 12'h000;
    wt(2);
    chk(15'h0, {p0PullupEn, pullupEn & 12'h3CE});
    $display("pull-up test done");
  endtask
  task automatic t_read();
    @(posedge clk);
    {p11In, p1In, p0In} <= 12'h639;
    wt(7);
    chk(16'h6393, {portRdData[47:44], portRdData[7:0], p1Filtered});
    $display("read test done");
  endtask
  task automatic t_flag();
    clr();
    @(posedge clk);
    p1In <= 4'h7;
    extEn[24] <= 1'b1;
    wt(6);
    chk(2'h3, {risingTestFlag, keyReturnFlag});
    clr();
    $display("flag test done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    wt(1);
    t_reset();
    t_dir();
    t_nib();
    t_pull();
    t_read();
    t_flag();
    final_report();
  end
  initial begin
    repeat (2000) @(posedge clk);
    errCount++;
    final_report();
  end
endmodule
